// [cac_pkg.sv]
/*
 cac_pkg: shared constants and types for the companding and loopback block.
 assumes one audio-interface clock and left-aligned interface words.
*/
package cac_pkg;
   // control register address and field positions
   localparam logic [6:0] CTL_ADDR = 7'h05;
   localparam int CTL_ADC_LB_BIT = 0;
   localparam int CTL_ADC_COMP_LO = 1;
   localparam int CTL_DAC_COMP_LO = 3;
   localparam int CTL_DAC_LB_BIT = 6;
   localparam logic [15:0] CTL_RESET = 16'h0000;
   localparam logic [15:0] CTL_WMASK = 16'h005F;
   // companding selector codes
   typedef enum logic [1:0] {
      CMP_OFF = 2'b00,
      CMP_RSV = 2'b01,
      CMP_MU = 2'b10,
      CMP_A = 2'b11
   } cac_comp_t;
   // control fields carried together
   typedef struct packed {
      logic dac_lb;
      cac_comp_t dac_comp;
      cac_comp_t adc_comp;
      logic adc_lb;
   } cac_ctl_t;
   // mu-law constants
   localparam logic [13:0] MU_CLIP = 14'h1FDF;
   localparam logic [13:0] MU_BIAS = 14'h0021;
   localparam logic [13:0] MU_OVF = 14'h2000;
   localparam logic [13:0] MU_SEG0 = 14'h0040;
   localparam logic [7:0] MU_INV = 8'hFF;
   localparam logic [15:0] MU_DBIAS = 16'h0084;
   // a-law constants
   localparam logic [11:0] A_SEG0 = 12'h020;
   localparam logic [7:0] A_INV = 8'h55;
   localparam logic [15:0] A_RND0 = 16'h0008;
   localparam logic [15:0] A_RND1 = 16'h0108;
   // interface word lengths in bits
   localparam logic [5:0] WLEN_8 = 6'd8;
   localparam logic [5:0] WLEN_16 = 6'd16;
   localparam logic [5:0] WLEN_20 = 6'd20;
   localparam logic [5:0] WLEN_24 = 6'd24;
   localparam logic [5:0] WLEN_32 = 6'd32;
   localparam int CODE_W = 8;
   localparam int FIFO_DEPTH = 16;
endpackage

// [cac_fifo.sv]
/*
 cac_fifo: synchronous valid/ready fifo, width and depth as parameters.
 assumes one clock and a synchronous active-low reset; depth a power of two.
*/
`timescale 1ns/1ns
module cac_fifo #(
   parameter int W = 32,
   parameter int D = 16
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];     // storage words
   logic [AW:0] wp_q;         // write pointer with wrap bit
   logic [AW:0] rp_q;         // read pointer with wrap bit
   logic push;
   logic pop;

   // full when pointers differ only in the wrap bit
   assign in_ready = !((wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]));
   assign out_valid = (wp_q != rp_q);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rp_q[AW-1:0]];

   // write pointer
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         wp_q <= '0;
      end else if (push) begin
         wp_q <= wp_q + 1'b1;
      end
   end

   // read pointer
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rp_q <= '0;
      end else if (pop) begin
         rp_q <= rp_q + 1'b1;
      end
   end

   // storage write, no reset needed
   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wp_q[AW-1:0]] <= in_data;
      end
   end
endmodule

// [cac_compander.sv]
/*
 cac_compander: companding and digital loopback logic of the audio interface.
 assumes capture samples arrive left-aligned from the adc filter, interface
 words are left-aligned, and the control port writes one register per cycle.
*/
`timescale 1ns/1ns
module cac_compander
   import cac_pkg::*;
#(
   parameter int SW = 16,
   parameter int IW = 32
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // control register port
   input wire logic reg_wr,
   input wire logic [6:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   // word length settings
   input wire logic packed_byte_width,
   input wire logic [1:0] interface_word_length,
   output logic [5:0] eff_word_len,
   // capture samples from the adc side
   input wire logic cap_valid,
   output logic cap_ready,
   input wire logic [SW-1:0] cap_data,
   // transmit words to the interface
   output logic tx_valid,
   input wire logic tx_ready,
   output logic [IW-1:0] tx_data,
   // received words from the interface
   input wire logic rx_valid,
   output logic rx_ready,
   input wire logic [IW-1:0] rx_data,
   // playback samples to the dac side
   output logic play_valid,
   input wire logic play_ready,
   output logic [SW-1:0] play_data
);
   // mu-law compressor on the top 14 bits (sign plus 13) of a sample
   function automatic logic [7:0] mu_enc(input logic [SW-1:0] s);
      logic [13:0] x;
      logic [13:0] m;
      logic [2:0] seg;
      logic [3:0] man;
      logic neg;
      x = s[SW-1 -: 14];
      neg = x[13];
      m = neg ? 14'(-x) : x;
      if (m > MU_CLIP) m = MU_CLIP;
      m = 14'(m + MU_BIAS);
      seg = '0;
      for (int i = 0; i < 7; i++) begin
         if (m >= (MU_SEG0 << i)) seg = 3'(i + 1);
      end
      // widened sum so that segment 7 shifts by eight, not by zero
      man = 4'(m >> (4'(seg) + 4'd1));
      if (m >= MU_OVF) mu_enc = {neg, 7'h7F} ^ MU_INV;
      else mu_enc = {neg, seg, man} ^ MU_INV;
   endfunction

   // a-law compressor on the top 13 bits (sign plus 12) of a sample
   function automatic logic [7:0] a_enc(input logic [SW-1:0] s);
      logic [12:0] x;
      logic [11:0] m;
      logic [2:0] seg;
      logic [3:0] man;
      x = s[SW-1 -: 13];
      m = x[12] ? ~x[11:0] : x[11:0];
      seg = '0;
      for (int i = 0; i < 7; i++) begin
         if (m >= (A_SEG0 << i)) seg = 3'(i + 1);
      end
      man = (seg < 3'd2) ? 4'(m >> 1) : 4'(m >> seg);
      a_enc = {~x[12], seg, man} ^ A_INV;
   endfunction

   // mu-law expander to a 16-bit left-aligned value
   function automatic logic [15:0] mu_dec(input logic [7:0] c);
      logic [7:0] u;
      logic [15:0] t;
      u = ~c;
      t = 16'(({12'h000, u[3:0]} << 3) + MU_DBIAS);
      t = t << u[6:4];
      mu_dec = u[7] ? 16'(MU_DBIAS - t) : 16'(t - MU_DBIAS);
   endfunction

   // a-law expander to a 16-bit left-aligned value
   function automatic logic [15:0] a_dec(input logic [7:0] c);
      logic [7:0] a;
      logic [15:0] t;
      a = c ^ A_INV;
      t = {8'h00, a[3:0], 4'h0};
      t = (a[6:4] == 3'd0) ? 16'(t + A_RND0) : 16'(t + A_RND1);
      if (a[6:4] > 3'd1) t = t << (a[6:4] - 3'd1);
      a_dec = a[7] ? t : 16'(-t);
   endfunction

   // mask keeping only the top len bits of an interface word
   function automatic logic [IW-1:0] len_mask(input logic [5:0] len);
      len_mask = ~({IW{1'b1}} >> len);
   endfunction

   logic [15:0] ctl_raw_q;    // stored control bits
   cac_ctl_t ctl;             // decoded control fields
   logic [5:0] wlen_q;        // effective word length
   logic [5:0] wlen_d;
   logic [IW-1:0] enc_word;   // capture sample after compression
   logic [IW-1:0] push_data;  // word entering the transmit fifo
   logic push_valid;
   logic push_ready;
   logic fifo_valid;
   logic [IW-1:0] fifo_data;
   logic fifo_pop;
   logic [IW-1:0] pb_word;    // word entering the expander
   logic pb_valid;
   logic pb_take;
   logic [SW-1:0] dec_data;
   logic [SW-1:0] play_q;
   logic play_valid_q;

   assign ctl = cac_ctl_t'({ctl_raw_q[CTL_DAC_LB_BIT], ctl_raw_q[CTL_DAC_COMP_LO +: 2],
                            ctl_raw_q[CTL_ADC_COMP_LO +: 2], ctl_raw_q[CTL_ADC_LB_BIT]});

   // control register write, reserved bits stay zero
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ctl_raw_q <= CTL_RESET;
      end else if (reg_wr && reg_addr == CTL_ADDR) begin
         ctl_raw_q <= reg_wdata & CTL_WMASK;
      end
   end

   // readback of the control register, other addresses read zero
   assign reg_rdata = (reg_addr == CTL_ADDR) ? ctl_raw_q : 16'h0000;

   // effective word length selection
   always_comb begin
      case (interface_word_length)
         2'b00: wlen_d = WLEN_16;
         2'b01: wlen_d = WLEN_20;
         2'b10: wlen_d = WLEN_24;
         default: wlen_d = WLEN_32;
      endcase
      if (packed_byte_width) wlen_d = WLEN_8;
   end

   // registered word length
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         wlen_q <= WLEN_16;
      end else begin
         wlen_q <= wlen_d;
      end
   end
   assign eff_word_len = wlen_q;

   // capture compression, code placed in the top byte
   always_comb begin
      case (ctl.adc_comp)
         CMP_MU: enc_word = {mu_enc(cap_data), {(IW - CODE_W){1'b0}}};
         CMP_A: enc_word = {a_enc(cap_data), {(IW - CODE_W){1'b0}}};
         default: enc_word = {cap_data, {(IW - SW){1'b0}}};
      endcase
   end

   // transmit source: capture or received-word loopback
   always_comb begin
      if (ctl.dac_lb) begin
         push_valid = rx_valid;
         push_data = rx_data;
      end else begin
         push_valid = cap_valid;
         push_data = enc_word & len_mask(wlen_d);
      end
   end
   assign cap_ready = push_ready && !ctl.dac_lb;

   cac_fifo #(
      .W(IW),
      .D(FIFO_DEPTH)
   ) u_txfifo (
      .mclk(mclk),
      .rst_n(rst_n),
      .in_valid(push_valid),
      .in_ready(push_ready),
      .in_data(push_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_data)
   );

   // fifo drains to the interface, or to playback in capture loopback
   assign tx_valid = fifo_valid && !ctl.adc_lb;
   assign tx_data = fifo_data;
   assign pb_take = !play_valid_q || play_ready;
   assign fifo_pop = ctl.adc_lb ? pb_take : tx_ready;

   // playback source selection
   always_comb begin
      if (ctl.adc_lb) begin
         pb_valid = fifo_valid;
         pb_word = fifo_data;
      end else begin
         pb_valid = rx_valid;
         pb_word = rx_data;
      end
   end
   // in rx loopback the fifo takes every received word, with or without capture loopback
   assign rx_ready = ctl.dac_lb ? push_ready : (pb_take && !ctl.adc_lb);

   // playback expansion from the top byte
   always_comb begin
      case (ctl.dac_comp)
         CMP_MU: dec_data = {mu_dec(pb_word[IW-1 -: CODE_W]), {(SW - 16){1'b0}}};
         CMP_A: dec_data = {a_dec(pb_word[IW-1 -: CODE_W]), {(SW - 16){1'b0}}};
         default: dec_data = pb_word[IW-1 -: SW];
      endcase
   end

   // playback output register
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         play_valid_q <= 1'b0;
         play_q <= '0;
      end else if (pb_take) begin
         play_valid_q <= pb_valid && (ctl.adc_lb || !ctl.dac_lb);
         if (pb_valid) play_q <= dec_data;
      end
   end
   assign play_valid = play_valid_q;
   assign play_data = play_q;

   // checks
   property p_packed_len;
      @(posedge mclk) disable iff (!rst_n) packed_byte_width |=> (eff_word_len == WLEN_8);
   endproperty
   a_packed_len: assert property (p_packed_len) else $error("packed length not 8");

   property p_mu_zero;
      @(posedge mclk) disable iff (!rst_n)
         (cap_valid && cap_ready && ctl.adc_comp == CMP_MU && cap_data == '0)
         |-> (push_data[IW-1 -: CODE_W] == 8'hFF);
   endproperty
   a_mu_zero: assert property (p_mu_zero) else $error("mu zero code wrong");

   property p_a_zero;
      @(posedge mclk) disable iff (!rst_n)
         (cap_valid && cap_ready && ctl.adc_comp == CMP_A && cap_data == '0)
         |-> (push_data[IW-1 -: CODE_W] == 8'hD5);
   endproperty
   a_a_zero: assert property (p_a_zero) else $error("a-law zero code wrong");

   property p_low_zero;
      @(posedge mclk) disable iff (!rst_n)
         (cap_valid && !ctl.dac_lb && ctl.adc_comp[1]) |-> (push_data[IW-CODE_W-1:0] == '0);
   endproperty
   a_low_zero: assert property (p_low_zero) else $error("code not in top byte");

   property p_dac_lb;
      @(posedge mclk) disable iff (!rst_n)
         (ctl.dac_lb && rx_valid && rx_ready) |-> (push_valid && push_data == rx_data);
   endproperty
   a_dac_lb: assert property (p_dac_lb) else $error("rx word not looped");

   property p_adc_lb;
      @(posedge mclk) disable iff (!rst_n) ctl.adc_lb |-> !tx_valid;
   endproperty
   a_adc_lb: assert property (p_adc_lb) else $error("tx active in loopback");

   property p_adc_lb_play;
      @(posedge mclk) disable iff (!rst_n)
         (ctl.adc_lb && fifo_valid && pb_take) |=> play_valid;
   endproperty
   a_adc_lb_play: assert property (p_adc_lb_play) else $error("looped word not played");

   property p_pass;
      @(posedge mclk) disable iff (!rst_n)
         (cap_valid && !ctl.dac_lb && !ctl.adc_comp[1] && wlen_d == WLEN_32)
         |-> (push_data[IW-1 -: SW] == cap_data);
   endproperty
   a_pass: assert property (p_pass) else $error("linear capture altered");

   property p_a_dec;
      @(posedge mclk) disable iff (!rst_n)
         (pb_take && pb_valid && !ctl.dac_lb && !ctl.adc_lb && ctl.dac_comp == CMP_A
          && pb_word[IW-1 -: CODE_W] == 8'hD5) |=> (play_data[SW-1 -: 16] == 16'h0008);
   endproperty
   a_a_dec: assert property (p_a_dec) else $error("a-law expand wrong");

   property p_reg;
      @(posedge mclk) disable iff (!rst_n)
         (reg_wr && reg_addr == CTL_ADDR) |=> (ctl_raw_q == ($past(reg_wdata) & CTL_WMASK));
   endproperty
   a_reg: assert property (p_reg) else $error("control write lost");
endmodule

// [cac_far_end.sv]
/*
 cac_far_end: model of the audio processor across the serial interface.
 assumes the bench queues received words in sq and drives stall.
*/
`timescale 1ns/1ns
module cac_far_end (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // transmit side
   input wire logic stall,
   output logic tx_ready,
   // receive side
   input wire logic rx_ready,
   output logic rx_valid,
   output logic [31:0] rx_data
);
   logic [31:0] sq[$]; // words waiting to go out
   // a stall holds ready low, otherwise words are taken at once
   assign tx_ready = !stall;
   // one word at a time, bus scrambled once released
   always @(posedge mclk) begin
      if (!rst_n) begin
         rx_valid <= 1'b0;
         rx_data <= 32'h0000_0000;
      end else if (rx_valid && rx_ready === 1'b1) begin
         rx_valid <= 1'b0;
         rx_data <= ~rx_data;
      end else if (!rx_valid && sq.size() > 0) begin
         rx_valid <= 1'b1;
         rx_data <= sq.pop_front();
      end
   end
endmodule

// [cac_compander_tb.sv]
/*
 cac_compander_tb: register, companding, loopback and fifo tests.
 assumes the far-end model and default widths of 16 and 32 bits.
*/
`timescale 1ns/1ns
module cac_compander_tb
   import cac_pkg::*;
;
   logic mclk, rst_n, reg_wr, packed_byte_width, stall, cap_valid, cap_ready;
   logic tx_valid, tx_ready, rx_valid, rx_ready, play_valid, play_ready;
   logic [6:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, cap_data, play_data;
   logic [1:0] interface_word_length;
   logic [5:0] eff_word_len;
   logic [31:0] tx_data, rx_data;
   logic [31:0] tq[$], pq[$]; // words seen leaving the block
   int n_fail = 0, cmp_count = 0;
   logic [15:0] smp[9] = '{16'h0000, 16'h0004, 16'h7FFF, 16'h8000,
      16'hFFFF, 16'h1234, 16'hEDCB, 16'h00FF, 16'h4000};
   cac_compander dut (.mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .packed_byte_width(packed_byte_width),
      .interface_word_length(interface_word_length), .eff_word_len(eff_word_len),
      .cap_valid(cap_valid), .cap_ready(cap_ready), .cap_data(cap_data),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid),
      .rx_ready(rx_ready), .rx_data(rx_data), .play_valid(play_valid),
      .play_ready(play_ready), .play_data(play_data));
   cac_far_end far (.mclk(mclk), .rst_n(rst_n), .stall(stall), .tx_ready(tx_ready),
      .rx_ready(rx_ready), .rx_valid(rx_valid), .rx_data(rx_data));
   // clock
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // collect every accepted output word
   always @(posedge mclk) begin
      if (tx_valid === 1'b1 && tx_ready) tq.push_back(tx_data);
      if (play_valid === 1'b1 && play_ready) pq.push_back({16'h0000, play_data});
   end
   // reference laws
   function automatic logic [7:0] mu_enc(logic [15:0] s);
      int p, m, g;
      p = $signed(s) >>> 2;
      m = 255;
      if (p < 0) begin
         p = -p;
         m = 127;
      end
      if (p > 8159) p = 8159;
      p = p + 33;
      g = 0;
      while (g < 8 && p > (64 << g) - 1) g++;
      if (g > 7) return 8'(127 ^ m);
      return 8'(((g << 4) | ((p >> (g + 1)) & 15)) ^ m);
   endfunction
   function automatic logic [7:0] a_enc(logic [15:0] s);
      int p, m, g;
      p = $signed(s) >>> 3;
      m = 213;
      if (p < 0) begin
         p = -p - 1;
         m = 85;
      end
      g = 0;
      while (g < 8 && p > (32 << g) - 1) g++;
      if (g > 7) return 8'(127 ^ m);
      return 8'(((g << 4) | ((p >> (g < 2 ? 1 : g)) & 15)) ^ m);
   endfunction
   function automatic logic [15:0] mu_dec(logic [7:0] c);
      int t;
      c = ~c;
      t = ((c & 15) << 3) + 132;
      t = t << ((c >> 4) & 7);
      return 16'(c[7] ? 132 - t : t - 132);
   endfunction
   function automatic logic [15:0] a_dec(logic [7:0] c);
      int t, g;
      c = c ^ 8'h55;
      t = (c & 15) << 4;
      g = (c >> 4) & 7;
      t = t + (g == 0 ? 8 : 264);
      if (g > 1) t = t << (g - 1);
      return 16'(c[7] ? t : -t);
   endfunction
   function automatic logic [31:0] tx_exp(int m, logic [15:0] s, int l);
      if (m == 2) return {mu_enc(s), 24'h00_0000};
      if (m == 3) return {a_enc(s), 24'h00_0000};
      return {s, 16'h0000} & ~(32'hFFFF_FFFF >> l);
   endfunction
   function automatic logic [31:0] pb_exp(int m, logic [31:0] w);
      if (m == 2) return {16'h0000, mu_dec(w[31:24])};
      if (m == 3) return {16'h0000, a_dec(w[31:24])};
      return {16'h0000, w[31:16]};
   endfunction
   // compare and count
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", n, e, g);
         n_fail++;
      end
   endtask
   task automatic wr(logic [6:0] a, logic [15:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(logic [6:0] a, logic [15:0] e);
      @(posedge mclk);
      reg_addr <= a;
      #1 chk("reg_rdata", {16'h0000, e}, {16'h0000, reg_rdata});
   endtask
   // offer one capture sample and hold it until taken
   task automatic cap(logic [15:0] s);
      int n;
      n = 0;
      @(posedge mclk);
      cap_valid <= 1'b1;
      cap_data <= s;
      @(posedge mclk);
      while (cap_ready !== 1'b1 && n < 100) begin
         n++;
         @(posedge mclk);
      end
      chk("cap_ready", 1, cap_ready);
      cap_valid <= 1'b0;
   endtask
   // wait for one output word, playback side when w is set
   task automatic pull(bit w, logic [31:0] e);
      int n;
      logic [31:0] g;
      n = 0;
      while ((w ? pq.size() : tq.size()) == 0 && n < 200) begin
         n++;
         @(posedge mclk);
      end
      g = 'x;
      if (w && pq.size() > 0) g = pq.pop_front();
      if (!w && tq.size() > 0) g = tq.pop_front();
      chk(w ? "play_data" : "tx_data", e, g);
   endtask
   task automatic conclude();
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // watchdog
   initial begin
      #500000;
      n_fail++;
      conclude();
   end
   // main sequence
   initial begin
      {rst_n, reg_wr, packed_byte_width, stall, cap_valid} = 5'b00000;
      {reg_addr, reg_wdata, cap_data, interface_word_length} = '0;
      play_ready = 1'b1;
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      rd(CTL_ADDR, 16'h0000);
      chk("eff_word_len", 16, eff_word_len);
      wr(CTL_ADDR, 16'hFFFF);
      rd(CTL_ADDR, 16'h005F);
      wr(7'h06, 16'h0000);
      rd(CTL_ADDR, 16'h005F);
      rd(7'h06, 16'h0000);
      for (int l = 0; l < 4; l++) begin
         @(posedge mclk);
         interface_word_length <= 2'(l);
         repeat (2) @(posedge mclk);
         chk("eff_word_len", l == 0 ? 16 : l == 1 ? 20 : l == 2 ? 24 : 32, eff_word_len);
      end
      // capture side in every selector code
      for (int m = 0; m < 4; m++) begin
         wr(CTL_ADDR, 16'(m << CTL_ADC_COMP_LO));
         foreach (smp[i]) begin
            cap(smp[i]);
            pull(0, tx_exp(m, smp[i], 32));
         end
      end
      // packed option narrows the word
      packed_byte_width <= 1'b1;
      repeat (2) @(posedge mclk);
      chk("eff_word_len", 8, eff_word_len);
      wr(CTL_ADDR, 16'h0000);
      cap(16'hABCD);
      pull(0, 32'hAB00_0000);
      wr(CTL_ADDR, 16'h0006);
      cap(16'hEDCB);
      pull(0, tx_exp(3, 16'hEDCB, 8));
      packed_byte_width <= 1'b0;
      // playback side, every code in every selector
      for (int m = 0; m < 4; m++) begin
         wr(CTL_ADDR, 16'(m << CTL_DAC_COMP_LO));
         for (int c = 0; c < 256; c++) begin
            far.sq.push_back({8'(c), 8'h3C, 16'h5AA5 ^ 16'(c)});
            pull(1, pb_exp(m, {8'(c), 8'h3C, 16'h5AA5 ^ 16'(c)}));
         end
      end
      // fifo filled while the far end stalls, then drained in order
      wr(CTL_ADDR, 16'h0000);
      stall <= 1'b1;
      for (int i = 0; i < 16; i++) cap(16'(i * 16'h0111));
      @(posedge mclk);
      chk("cap_ready", 0, cap_ready);
      stall <= 1'b0;
      for (int i = 0; i < 16; i++) pull(0, {16'(i * 16'h0111), 16'h0000});
      // received words looped to transmit unchanged
      wr(CTL_ADDR, 16'h0054);
      far.sq.push_back(32'h1357_9BDF);
      pull(0, 32'h1357_9BDF);
      chk("cap_ready", 0, cap_ready);
      chk("play_count", 0, pq.size());
      // captured samples looped to playback, then a received word with both loopbacks on
      wr(CTL_ADDR, 16'h0015);
      cap(16'h1234);
      pull(1, {16'h0000, mu_dec(mu_enc(16'h1234))});
      chk("rx_ready", 0, rx_ready);
      chk("tx_count", 0, tq.size());
      wr(CTL_ADDR, 16'h0041);
      far.sq.push_back(32'hCAFE_0001);
      pull(1, 32'h0000_CAFE);
      repeat (8) @(posedge mclk);
      chk("play_count", 0, pq.size());
      // playback held off: received words wait, then leave in order
      wr(CTL_ADDR, 16'h0000);
      play_ready <= 1'b0;
      far.sq.push_back(32'h1111_0000);
      far.sq.push_back(32'h2222_0000);
      repeat (8) @(posedge mclk);
      chk("rx_ready", 0, rx_ready);
      chk("play_valid", 1, play_valid);
      play_ready <= 1'b1;
      pull(1, 32'h0000_1111);
      pull(1, 32'h0000_2222);
      // reset in mid-run returns the control register to zero
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      rd(CTL_ADDR, 16'h0000);
      chk("tx_valid", 0, tx_valid);
      chk("play_valid", 0, play_valid);
      conclude();
   end
endmodule
